/* logic/dmc_cache.sv */
// Direct-mapped write-through cache top level
module dmc_cache #(
  parameter int  DATA_W = 16,
  parameter bit  BYPASS_INVALIDATE = 1'b0
) (
  input  wire logic                core_clk,          // Clock, 50 MHz
  input  wire logic                rstn,              // Async reset, active low
  input  wire logic                cpu_rd_start,      // CPU read start pulse
  input  wire logic                cpu_wr_start,      // CPU write start pulse
  input  wire logic [21:0]         cpu_addr,          // Physical address
  input  wire logic [DATA_W-1:0]   cpu_wdata,         // CPU write data
  input  wire logic                cpu_bypass,        // Page bypass flag
  input  wire logic                cpu_periph,        // Access in peripheral space
  input  wire logic                upper_half_miss_switch, // Force miss, bit 12 one
  input  wire logic                lower_half_miss_switch, // Force miss, bit 12 zero
  input  wire logic                sw_cache_enable,   // Software caching enable
  input  wire logic                mem_done,          // Main memory slave reply
  input  wire logic [DATA_W-1:0]   mem_rdata,         // Main memory read data
  input  wire logic                dma_wr,            // DMA write strobe
  input  wire logic [21:0]         dma_addr,          // DMA write address
  output logic                     master_sync_strobe, // Main memory request
  output logic                     mem_write,         // Request is a write
  output logic                     clk_restart,       // Processor clock restart pulse
  output logic [DATA_W-1:0]        cpu_rdata,         // Word for CPU
  output logic                     hit_flag           // Last read was a hit
);
  localparam int IW = dmc_pkg::IDX_W;
  localparam int TW = dmc_pkg::TAG_W;
  localparam int EW = 1 + TW + 1 + DATA_W + 2;

  // Elaboration checks: the fields must tile the address and the delay must fit the counter
  if (DATA_W != 16) begin : g_bad_data_w
    $error("dmc_cache: only 16-bit data is served");
  end
  if (dmc_pkg::IDX_LSB + IW != dmc_pkg::TAG_LSB) begin : g_bad_index
    $error("dmc_cache: index field must end below the tag field");
  end
  if (dmc_pkg::TAG_LSB + TW != dmc_pkg::ADDR_W) begin : g_bad_tag
    $error("dmc_cache: tag field must end at the top address bit");
  end
  if (dmc_pkg::HALF_BIT < dmc_pkg::IDX_LSB ||
      dmc_pkg::HALF_BIT >= dmc_pkg::TAG_LSB) begin : g_bad_half
    $error("dmc_cache: half select bit must lie in the index");
  end
  if (dmc_pkg::LOOKUP_CYC < 2 || dmc_pkg::LOOKUP_CYC > 15) begin : g_bad_lookup
    $error("dmc_cache: lookup delay does not fit the counter");
  end
  if (EW != dmc_pkg::ENTRY_W) begin : g_bad_entry
    $error("dmc_cache: entry layout differs from the package");
  end

  dmc_pkg::dmc_state_t state;
  logic [21:0]       addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic              write_q, bypass_q, periph_q;
  logic [3:0]        cnt;
  logic [EW-1:0]     rd_entry;
  logic              wr_en;
  logic [IW-1:0]     wr_idx;
  logic [EW-1:0]     wr_data;
  logic [IW-1:0]     rd_idx;

  // Index follows the CPU address while idle, so the entry is read at the taking edge
  assign rd_idx = (state == dmc_pkg::DMC_IDLE) ?
                  cpu_addr[dmc_pkg::IDX_LSB +: IW] : addr_q[dmc_pkg::IDX_LSB +: IW];

  dmc_array #(.DEPTH_LOG(IW), .WIDTH(EW)) u_array (
    .core_clk (core_clk),
    .rd_idx   (rd_idx),
    .rd_data  (rd_entry),
    .wr_en    (wr_en),
    .wr_idx   (wr_idx),
    .wr_data  (wr_data)
  );

  // Entry: valid, tag, tag parity, data, byte parity hi/lo
  logic             e_valid, e_tpar, e_phi, e_plo;
  logic [TW-1:0]    e_tag;
  logic [DATA_W-1:0] e_data;
  assign {e_valid, e_tag, e_tpar, e_data, e_phi, e_plo} = rd_entry;

  logic par_err, tag_match, held, forced, lookup_hit;
  assign par_err   = (e_tpar != ^e_tag) || (e_phi != ^e_data[15:8]) ||
                     (e_plo != ^e_data[7:0]);
  assign tag_match = e_valid && (e_tag == addr_q[dmc_pkg::TAG_LSB +: TW]);
  assign held      = tag_match && !par_err;
  assign forced    = !sw_cache_enable || periph_q ||
                     (addr_q[dmc_pkg::HALF_BIT] ? upper_half_miss_switch
                                                : lower_half_miss_switch);
  assign lookup_hit = held && !forced && !bypass_q;

  // A CPU update that meets a DMA invalidation waits, so neither write is lost
  logic cpu_upd, upd_stall;
  assign cpu_upd   = (write_q && held) ||
                     (!write_q && bypass_q && tag_match && BYPASS_INVALIDATE);
  assign upd_stall = (state == dmc_pkg::DMC_DECIDE) && cpu_upd && dma_wr;

  // A DMA write to the line being fetched makes the fetched word stale: skip its fill
  logic fill_kill;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fill_kill <= 1'b0;
    end else if (state == dmc_pkg::DMC_IDLE) begin
      fill_kill <= 1'b0;
    end else if (dma_wr &&
                 dma_addr[dmc_pkg::IDX_LSB +: IW] == addr_q[dmc_pkg::IDX_LSB +: IW]) begin
      fill_kill <= 1'b1;
    end
  end

  function automatic logic [EW-1:0] make_entry(input logic [21:0] a,
                                               input logic [DATA_W-1:0] d);
    logic [TW-1:0] t;
    t = a[dmc_pkg::TAG_LSB +: TW];
    make_entry = {1'b1, t, ^t, d, ^d[15:8], ^d[7:0]};
  endfunction

  // Array write port: fill, write hit update, invalidation
  always_comb begin
    wr_en   = 1'b0;
    wr_idx  = addr_q[dmc_pkg::IDX_LSB +: IW];
    wr_data = make_entry(addr_q, wdata_q);
    if (dma_wr) begin
      wr_en   = 1'b1;
      wr_idx  = dma_addr[dmc_pkg::IDX_LSB +: IW];
      wr_data = '0;
    end else if (state == dmc_pkg::DMC_DECIDE && write_q && held) begin
      wr_en   = 1'b1;
      wr_data = (bypass_q || forced) ? '0 : make_entry(addr_q, wdata_q);
    end else if (state == dmc_pkg::DMC_DECIDE && !write_q && bypass_q && tag_match &&
                 BYPASS_INVALIDATE) begin
      wr_en   = 1'b1;
      wr_data = '0;
    end else if (state == dmc_pkg::DMC_FILL && !bypass_q && !periph_q && !forced &&
                 !fill_kill) begin
      // Reply data is only valid with the reply, so the registered copy is written
      wr_en   = 1'b1;
      wr_data = make_entry(addr_q, cpu_rdata);
    end
  end

  // Decide is held while a DMA invalidation owns the write port and a CPU update is pending
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= dmc_pkg::DMC_IDLE;
      cnt   <= dmc_pkg::CNT_RESET;
    end else begin
      case (state)
        dmc_pkg::DMC_IDLE: begin
          cnt <= dmc_pkg::CNT_RESET;
          if (cpu_rd_start || cpu_wr_start) begin
            state <= dmc_pkg::DMC_LOOK;
          end
        end
        dmc_pkg::DMC_LOOK: begin
          cnt <= cnt + 4'h1;
          if (cnt == 4'(dmc_pkg::LOOKUP_CYC - 2)) begin
            state <= dmc_pkg::DMC_DECIDE;
          end
        end
        dmc_pkg::DMC_DECIDE: begin
          if (upd_stall) begin
            state <= dmc_pkg::DMC_DECIDE;
          end else if (!write_q && lookup_hit) begin
            state <= dmc_pkg::DMC_IDLE;
          end else begin
            state <= dmc_pkg::DMC_MEM;
          end
        end
        dmc_pkg::DMC_MEM: begin
          if (mem_done) begin
            state <= write_q ? dmc_pkg::DMC_IDLE : dmc_pkg::DMC_FILL;
          end
        end
        dmc_pkg::DMC_FILL: state <= dmc_pkg::DMC_IDLE;
        default: state <= dmc_pkg::DMC_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      addr_q   <= 22'h000000;
      wdata_q  <= 16'h0000;
      write_q  <= 1'b0;
      bypass_q <= 1'b0;
      periph_q <= 1'b0;
    end else if (state == dmc_pkg::DMC_IDLE && (cpu_rd_start || cpu_wr_start)) begin
      addr_q   <= cpu_addr;
      wdata_q  <= cpu_wdata;
      write_q  <= cpu_wr_start;
      bypass_q <= cpu_bypass;
      periph_q <= cpu_periph;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      master_sync_strobe <= 1'b0;
      mem_write          <= 1'b0;
    end else if (state == dmc_pkg::DMC_DECIDE && !upd_stall && (write_q || !lookup_hit)) begin
      master_sync_strobe <= 1'b1;
      mem_write          <= write_q;
    end else if (mem_done) begin
      master_sync_strobe <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clk_restart <= 1'b0;
      cpu_rdata   <= 16'h0000;
      hit_flag    <= 1'b0;
    end else begin
      clk_restart <= 1'b0;
      if (state == dmc_pkg::DMC_DECIDE && !write_q && !upd_stall) begin
        hit_flag <= lookup_hit;
        if (lookup_hit) begin
          clk_restart <= 1'b1;
          cpu_rdata   <= e_data;
        end
      end else if (state == dmc_pkg::DMC_MEM && mem_done) begin
        clk_restart <= 1'b1;
        cpu_rdata   <= write_q ? cpu_rdata : mem_rdata;
      end
    end
  end
endmodule // dmc_cache

/* logic/dmc_pkg.sv */
// Package of constants for the direct-mapped write-through cache
// Functional notes
// - 8192 bytes of storage, direct mapped, every CPU store written through
// - Lookup sampled 100 ns after read start; hit needs valid, tag match, no error
// - Read hit restarts processor clock and presents cached word without memory
// - Read miss asserts master sync; returned word written into the array
// - Writes always go to memory; cache updated only if location held
// - DMA writes from peripheral bus invalidate matching cached entries
// - Only CPU transfers to main memory are cached, never peripheral space
// - Two switches force misses on upper or lower cache half
// - Per-page bypass flag stops use of cached copy
// - Bypassed access always obtains its word from main memory
// - Software enable and disable of caching beside the switches
// - Physical address bit 12 selects upper (one) or lower (zero) half
// - Bypassed read hit forces a miss by default, or invalidates if selected
// - Parity error in the array during lookup forces a miss
package dmc_pkg;
  localparam int          CLK_MHZ       = 50;
  localparam int          LOOKUP_NS     = 100;
  localparam int          LOOKUP_CYC    = (LOOKUP_NS * CLK_MHZ + 999) / 1000;
  localparam int          ADDR_W        = 22;
  localparam int          IDX_LSB       = 1;
  localparam int          IDX_W         = 12;
  localparam int          TAG_LSB       = 13;
  localparam int          TAG_W         = 9;
  localparam int          HALF_BIT      = 12;
  localparam int          DATA_W        = 16;
  localparam int          ENTRY_W       = 1 + TAG_W + 1 + DATA_W + 2;
  localparam logic [3:0]  CNT_RESET     = 4'h0;
  typedef enum logic [2:0] {
    DMC_IDLE = 3'b000,
    DMC_LOOK = 3'b001,
    DMC_DECIDE = 3'b011,
    DMC_MEM  = 3'b010,
    DMC_FILL = 3'b110
  } dmc_state_t;
endpackage

/* logic/dmc_array.sv */
// Entry store of the cache with registered read data
module dmc_array #(
  parameter int DEPTH_LOG = 12,
  parameter int WIDTH     = 29
) (
  input  wire logic                 core_clk,   // Clock
  input  wire logic [DEPTH_LOG-1:0] rd_idx,     // Read index
  output logic      [WIDTH-1:0]     rd_data,    // Registered read data
  input  wire logic                 wr_en,      // Write strobe
  input  wire logic [DEPTH_LOG-1:0] wr_idx,     // Write index
  input  wire logic [WIDTH-1:0]     wr_data     // Write data
);
  logic [WIDTH-1:0] mem [0:(1<<DEPTH_LOG)-1];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    rd_data <= mem[rd_idx];
  end
endmodule // dmc_array

/* tb/dmc_chk.sv */
// Assertion checker for the cache top level
module dmc_chk #(
  parameter int DATA_W = 16
) (
  input wire logic              core_clk,               // Clock
  input wire logic              rstn,                   // Reset
  input wire logic              cpu_rd_start,           // Read
  input wire logic              cpu_wr_start,           // Write
  input wire logic [21:0]       cpu_addr,               // Address
  input wire logic              cpu_bypass,             // Bypass
  input wire logic              cpu_periph,             // Periph
  input wire logic              upper_half_miss_switch, // Upper
  input wire logic              lower_half_miss_switch, // Lower
  input wire logic              sw_cache_enable,        // Enable
  input wire logic              mem_done,               // Reply
  input wire logic [DATA_W-1:0] mem_rdata,              // Reply data
  input wire logic              master_sync_strobe,     // Request
  input wire logic              mem_write,              // Write req
  input wire logic              clk_restart,            // Done
  input wire logic [DATA_W-1:0] cpu_rdata,              // Word
  input wire logic              hit_flag                // Hit
);
  logic busy;
  wire logic rd = cpu_rd_start && !busy;
  wire logic wr = cpu_wr_start && !busy;
  wire logic hi = cpu_addr[12] ? upper_half_miss_switch : lower_half_miss_switch;
  wire logic forced = cpu_bypass || cpu_periph || !sw_cache_enable || hi;
  // Starts while busy are ignored by the design, so they must not arm checks
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn) busy <= 1'b0;
    else if (rd || wr) busy <= 1'b1;
    else if (clk_restart) busy <= 1'b0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  chk_read_answer: assert property (rd |-> ##[5:6] (clk_restart || master_sync_strobe))
    else $error("read answer late");
  chk_forced_miss: assert property (rd && forced |-> ##[5:6] master_sync_strobe)
    else $error("forced read not sent to memory");
  chk_write_thru: assert property (wr |-> ##[5:6] (master_sync_strobe && mem_write))
    else $error("write not sent to memory");
  chk_hit_local: assert property ($rose(hit_flag) |-> clk_restart && !master_sync_strobe)
    else $error("hit used memory");
  chk_strobe_hold: assert property (master_sync_strobe && !mem_done |=> master_sync_strobe)
    else $error("request dropped early");
  chk_reply_ends: assert property (master_sync_strobe && mem_done |=> clk_restart && !master_sync_strobe)
    else $error("reply did not end transfer");
  chk_miss_data: assert property (master_sync_strobe && mem_done && !mem_write |=> cpu_rdata == $past(mem_rdata) && !hit_flag)
    else $error("miss word wrong");
  chk_restart_pulse: assert property (clk_restart |=> !clk_restart)
    else $error("restart not a pulse");
  cover property (rd ##[5:6] (clk_restart && hit_flag));
  cover property (rd && forced ##[5:6] master_sync_strobe);
  cover property (wr ##[5:6] mem_write);
endmodule // dmc_chk

bind dmc_cache dmc_chk #(.DATA_W(DATA_W)) i_dmc_chk (.*);

/* tb/dmc_mem_model.sv */
// Main memory partner answering the cache requests
module dmc_mem_model (
  input  wire logic        core_clk,           // Clock
  input  wire logic        rstn,               // Reset
  input  wire logic        master_sync_strobe, // Request
  input  wire logic        mem_write,          // Write req
  input  wire logic [21:0] cpu_addr,           // Address
  input  wire logic [15:0] cpu_wdata,          // Write data
  input  wire logic        slow,               // Long latency
  output logic             mem_done,           // Reply
  output logic [15:0]      mem_rdata           // Read data
);
  logic [15:0] store[logic [20:0]];
  logic [2:0]  cnt;
  // Data toggles outside replies so a late capture shows up as wrong
  always @(posedge core_clk or negedge rstn)
    if (!rstn) {mem_done, cnt, mem_rdata} <= '0;
    else if (master_sync_strobe && !mem_done && cnt < (slow ? 3'h6 : 3'h1))
      {mem_done, cnt, mem_rdata} <= {1'b0, cnt + 3'h1, ~mem_rdata};
    else if (master_sync_strobe && !mem_done) begin
      {mem_done, cnt} <= {1'b1, 3'h0};
      if (mem_write) store[cpu_addr[21:1]] = cpu_wdata;
      mem_rdata <= store.exists(cpu_addr[21:1]) ? store[cpu_addr[21:1]]
                                                : cpu_addr[16:1] ^ 16'ha5c3;
    end else {mem_done, mem_rdata} <= {1'b0, ~mem_rdata};
endmodule // dmc_mem_model

/* tb/testbench.sv */
// Self-checking testbench for the cache
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rstn, cpu_rd_start, cpu_wr_start, cpu_bypass, cpu_periph, sw_cache_enable;
  logic upper_half_miss_switch, lower_half_miss_switch, mem_done, dma_wr, slow;
  logic master_sync_strobe, mem_write, clk_restart, hit_flag;
  logic [21:0] cpu_addr, dma_addr, r, a, b, c, e;
  logic [15:0] cpu_wdata, mem_rdata, cpu_rdata;
  logic [17:0] exp_q[$];
  logic [15:0] sh[logic [20:0]];
  int          n_mismatch, cmp_count;
  dmc_cache i_dmc_cache (.*);
  dmc_mem_model i_dmc_mem_model (.*);
  always #10 core_clk = ~core_clk;
  function automatic logic [21:0] rnd();
    r = {r[20:0], r[21] ^ r[20]};
    return r & 22'h3ffffe;
  endfunction
  function automatic logic [15:0] mval(logic [21:0] x);
    return sh.exists(x[21:1]) ? sh[x[21:1]] : x[16:1] ^ 16'ha5c3;
  endfunction
  task automatic check(string nm, logic [16:0] seen, logic [16:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic op(logic w, logic [21:0] x, logic [15:0] d, logic byp, logic per, logic h);
    @(posedge core_clk);
    {cpu_rd_start, cpu_wr_start, cpu_addr, cpu_wdata} <= {!w, w, x, d};
    {cpu_bypass, cpu_periph, slow} <= {byp, per, x[3] ^ d[0]};
    exp_q.push_back({!w, h, mval(x)});
    if (w) sh[x[21:1]] = d;
    @(posedge core_clk);
    {cpu_rd_start, cpu_wr_start} <= 2'b00;
    while (!clk_restart) @(posedge core_clk);
  endtask
  always @(posedge core_clk) if (rstn && clk_restart) begin : mon
    logic [17:0] q;
    if (exp_q.size() == 0) check("orphan", 17'h1, 17'h0);
    else begin
      q = exp_q.pop_front();
      if (q[17]) check("read", {hit_flag, cpu_rdata}, q[16:0]);
    end
  end
  initial begin
    #1ms;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {core_clk, rstn, cpu_rd_start, cpu_wr_start, cpu_bypass, cpu_periph, dma_wr, slow} = '0;
    {upper_half_miss_switch, lower_half_miss_switch, cpu_addr, dma_addr, cpu_wdata} = '0;
    sw_cache_enable = 1'b1;
    r = 22'h00002d;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    // Array contents power up random, so every entry is cleared first
    for (int i = 0; i < 4096; i++) begin
      @(posedge core_clk);
      {dma_wr, dma_addr} <= {1'b1, 9'h0, i[11:0], 1'b0};
    end
    @(posedge core_clk);
    dma_wr <= 1'b0;
    a = rnd();
    c = rnd();
    b = a ^ 22'h002000;
    e = a ^ 22'h001000;
    op(0, a, 0, 0, 0, 0);
    op(0, a, 0, 0, 0, 1);
    op(0, b, 0, 0, 0, 0);
    op(0, a, 0, 0, 0, 0);
    op(1, a, r[15:0], 0, 0, 0);
    op(0, a, 0, 0, 0, 1);
    op(1, b, ~r[15:0], 0, 0, 0);
    op(0, b, 0, 0, 0, 0);
    op(0, a, 0, 0, 0, 0);
    @(posedge core_clk);
    {dma_wr, dma_addr} <= {1'b1, a};
    @(posedge core_clk);
    dma_wr <= 1'b0;
    op(0, a, 0, 0, 0, 0);
    op(0, c, 0, 0, 1, 0);
    op(0, c, 0, 0, 1, 0);
    op(0, c, 0, 0, 0, 0);
    op(0, a, 0, 1, 0, 0);
    op(0, a, 0, 0, 0, 1);
    op(0, e, 0, 0, 0, 0);
    for (int s = 0; s < 4; s++) begin
      {upper_half_miss_switch, lower_half_miss_switch} <= s[1:0];
      op(0, a, 0, 0, 0, !(a[12] ? s[1] : s[0]));
      op(0, e, 0, 0, 0, !(e[12] ? s[1] : s[0]));
    end
    {upper_half_miss_switch, lower_half_miss_switch, sw_cache_enable} <= 3'b000;
    op(0, a, 0, 0, 0, 0);
    sw_cache_enable <= 1'b1;
    op(0, a, 0, 0, 0, 1);
    @(posedge core_clk);
    check("pending", 17'(exp_q.size()), 17'h0);
    print_verdict();
  end
endmodule // testbench
